// ===== core/ipa_regs.sv
// pending, active and priority registers of the vectored interrupt controller
`timescale 1ns/1ps
// What this block does
// - writing one to set-pending makes interrupt pending; zero no effect; read shows pending
// - set-pending on an already pending interrupt changes nothing
// - set-pending works even when the interrupt is disabled
// - writing one to clear-pending removes pending; zero no effect; reads pending
// - clearing pending never touches the active state
// - active-flag register reads one for active or active-and-pending interrupts
// - nine priority registers, four 4-bit fields each, interrupts 0 to 32
// - priority registers accept byte accesses without touching neighbours
// - priority 0 to 15, lower value means higher priority
// - only bits 7:4 of each lane stored; bits 3:0 read zero
// - interrupt N priority sits in register N div 4, lane N mod 4
// - lane 0 is bits 7:0 up to lane 3 bits 31:24
// - pending but disabled interrupt is never offered for activation
// - request line rising edge, or high while not active, makes pending
module ipa_regs
   import ipa_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [32:0] irq_line,
   input wire logic [32:0] irq_enable,
   input wire ipa_core_type core_in,
   output ipa_req_type irq_req,
   output logic irq_out
);

   ////////////////////////////////////////////////////////////////////////////
   // state
   logic [32:0] pend_r;
   logic [32:0] pend_nxt;
   logic [32:0] active_r;
   logic [32:0] line_prev_r;
   logic [3:0] prio_r [0:35];
   logic [1:0] ev_status_r;
   logic [1:0] ev_mask_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   ipa_req_type irq_req_r;
   logic irq_out_r;

   // which register a bus address selects
   typedef enum logic [2:0] {
      SEL_NONE,
      SEL_SET,
      SEL_CLEAR,
      SEL_ACTIVE,
      SEL_PRIO,
      SEL_STATUS,
      SEL_MASK
   } ipa_sel_type;

   ////////////////////////////////////////////////////////////////////////////
   // helpers
   // byte-enable mask from the strobes
   function automatic logic [31:0] lane_mask(input logic [3:0] strb);
      logic [31:0] m;
      m = 32'h0000_0000;
      for (int l = 0; l < LANES; l++) begin
         m[l*8 +: 8] = {8{strb[l]}};
      end
      return m;
   endfunction

   // register index of a priority offset
   function automatic logic [3:0] prio_index(input logic [11:0] addr);
      logic [11:0] d;
      d = addr - OFS_PRIORITY_0;
      return d[5:2];
   endfunction

   // bit position of a stored priority nibble inside its word
   function automatic int field_lsb(input int lane);
      return lane * 8 + PRIO_LSB;
   endfunction

   // flat field number of one lane of a priority register
   function automatic int field_num(input logic [3:0] idx, input int lane);
      return int'(idx) * LANES + lane;
   endfunction

   // word-aligned address inside the priority bank
   function automatic logic is_prio(input logic [11:0] addr);
      return (addr >= OFS_PRIORITY_0) && (addr <= OFS_PRIORITY_8) && (addr[1:0] == 2'h0);
   endfunction

   // register selected by a byte address
   function automatic ipa_sel_type reg_sel(input logic [11:0] addr);
      ipa_sel_type s;
      case (addr)
         OFS_SET_PENDING: begin
            s = SEL_SET;
         end
         OFS_CLEAR_PENDING: begin
            s = SEL_CLEAR;
         end
         OFS_ACTIVE_FLAGS: begin
            s = SEL_ACTIVE;
         end
         OFS_EVENT_STATUS: begin
            s = SEL_STATUS;
         end
         OFS_EVENT_MASK: begin
            s = SEL_MASK;
         end
         default: begin
            s = is_prio(addr) ? SEL_PRIO : SEL_NONE;
         end
      endcase
      return s;
   endfunction

   // any implemented word
   function automatic logic is_mapped(input logic [11:0] addr);
      return reg_sel(addr) != SEL_NONE;
   endfunction

   // highest priority candidate, lowest value wins, ties to lowest index
   function automatic ipa_req_type pick(input logic [32:0] cand, input logic [3:0] pr [0:35]);
      ipa_req_type best;
      best = '0;
      for (int i = 0; i < NUM_IRQ; i++) begin
         if (cand[i] && (!best.valid || (pr[i] < best.prio))) begin
            best.valid = 1'b1;
            best.id = 6'(i);
            best.prio = pr[i];
         end
      end
      return best;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // decoded bus strobes
   logic setup_phase;
   logic access_done;
   logic wr_done;
   logic rd_done;
   logic [31:0] wmask;
   logic [32:0] sw_set;
   logic [32:0] sw_clr;
   logic [32:0] hw_set;
   logic [32:0] core_entry;
   logic [32:0] core_leave;
   logic [3:0] pidx;
   ipa_sel_type sel;
   logic hit_set;
   logic hit_clear;
   logic hit_active;
   logic hit_status;
   logic hit_mask;
   logic hit_prio;
   logic status_rd;
   logic mask_wr;
   logic [3:0] prio_lane_we;
   logic [32:0] edge_set;
   logic [32:0] level_set;
   logic [32:0] offer_cand;

   assign setup_phase = psel && !penable;
   assign access_done = psel && penable && pready_r;
   assign wr_done = access_done && pwrite && !pslverr_r;
   assign rd_done = access_done && !pwrite && !pslverr_r;
   assign wmask = lane_mask(pstrb);
   assign pidx = prio_index(paddr);

   // register hits and qualified strobes
   assign sel = reg_sel(paddr);
   assign hit_set = (sel == SEL_SET);
   assign hit_clear = (sel == SEL_CLEAR);
   assign hit_active = (sel == SEL_ACTIVE);
   assign hit_status = (sel == SEL_STATUS);
   assign hit_mask = (sel == SEL_MASK);
   assign hit_prio = (sel == SEL_PRIO);
   assign status_rd = rd_done && hit_status;
   assign mask_wr = wr_done && hit_mask && pstrb[0];
   assign prio_lane_we = {LANES{wr_done && hit_prio}} & pstrb;

   // offer candidates: pending, enabled and not yet in service
   assign offer_cand = pend_r & irq_enable & ~active_r;

   // software set and clear vectors, only written lanes count
   always_comb begin
      sw_set = RST_IRQ_VEC;
      sw_clr = RST_IRQ_VEC;
      if (wr_done && hit_set) begin
         sw_set[31:0] = pwdata & wmask;
      end
      if (wr_done && hit_clear) begin
         sw_clr[31:0] = pwdata & wmask;
      end
   end

   // hardware request detection; a handler being entered must not re-pend from its own level
   assign edge_set = irq_line & ~line_prev_r;
   assign level_set = irq_line & ~active_r & ~core_entry;
   assign hw_set = edge_set | level_set;

   // exception entry and return from the core
   always_comb begin
      core_entry = RST_IRQ_VEC;
      core_leave = RST_IRQ_VEC;
      if (core_in.entry && (core_in.entry_id < 6'(NUM_IRQ))) begin
         core_entry[core_in.entry_id] = 1'b1;
      end
      if (core_in.leave && (core_in.leave_id < 6'(NUM_IRQ))) begin
         core_leave[core_in.leave_id] = 1'b1;
      end
   end

   // pending next value; setting wins over clearing
   always_comb begin
      pend_nxt = (pend_r & ~sw_clr & ~core_entry) | sw_set | hw_set;
   end

   ////////////////////////////////////////////////////////////////////////////
   // one shared pending flag per interrupt
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pend_r <= RST_IRQ_VEC;
      end else if (ce) begin
         pend_r <= pend_nxt;
      end
   end

   // active flags, untouched by pending clears
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         active_r <= RST_IRQ_VEC;
      end else if (ce) begin
         active_r <= (active_r & ~core_leave) | core_entry;
      end
   end

   // previous request levels for edge detection
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         line_prev_r <= RST_IRQ_VEC;
      end else if (ce) begin
         line_prev_r <= irq_line;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // priority fields, byte writable, upper nibble only
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         for (int f = 0; f < NUM_PRIO_FIELDS; f++) begin
            prio_r[f] <= RST_PRIO;
         end
      end else if (ce) begin
         for (int l = 0; l < LANES; l++) begin
            if (prio_lane_we[l]) begin
               prio_r[field_num(pidx, l)] <= pwdata[field_lsb(l) +: PRIO_W];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // event status, read clears, new event wins over the clear
   logic [1:0] ev_set;
   assign ev_set[EV_HW_PEND] = |(hw_set & ~pend_r);
   assign ev_set[EV_SW_PEND] = |(sw_set & ~pend_r);

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ev_status_r <= RST_EV;
      end else if (ce) begin
         if (status_rd) begin
            ev_status_r <= ev_set;
         end else begin
            ev_status_r <= ev_status_r | ev_set;
         end
      end
   end

   // event mask
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ev_mask_r <= RST_EV;
      end else if (ce && mask_wr) begin
         ev_mask_r <= pwdata[1:0];
      end
   end

   // interrupt output level
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         irq_out_r <= 1'b0;
      end else if (ce) begin
         irq_out_r <= |(ev_status_r & ev_mask_r);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data, captured in the setup cycle
   logic [31:0] rdata;
   always_comb begin
      rdata = RST_WORD;
      if (hit_set || hit_clear) begin
         rdata = pend_r[31:0];
      end else if (hit_active) begin
         rdata = active_r[31:0];
      end else if (hit_status) begin
         rdata = {30'h0, ev_status_r};
      end else if (hit_mask) begin
         rdata = {30'h0, ev_mask_r};
      end else if (hit_prio) begin
         for (int l = 0; l < LANES; l++) begin
            rdata[field_lsb(l) +: PRIO_W] = prio_r[field_num(pidx, l)];
         end
      end
   end

   // apb read data, snapshot of the setup cycle
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         prdata_r <= RST_WORD;
      end else if (ce) begin
         if (setup_phase) begin
            prdata_r <= pwrite ? RST_WORD : rdata;
         end
      end
   end

   // apb ready, high in the first access cycle only
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pready_r <= 1'b0;
      end else if (ce) begin
         if (setup_phase) begin
            pready_r <= 1'b1;
         end else if (access_done) begin
            pready_r <= 1'b0;
         end
      end
   end

   // apb error for unmapped words, stands with ready
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pslverr_r <= 1'b0;
      end else if (ce) begin
         if (setup_phase) begin
            pslverr_r <= !is_mapped(paddr);
         end else if (access_done) begin
            pslverr_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // activation offer to the core: enabled pending and not yet active
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         irq_req_r <= '0;
      end else if (ce) begin
         irq_req_r <= pick(offer_cand, prio_r);
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign irq_req = irq_req_r;
   assign irq_out = irq_out_r;

endmodule // ipa_regs

// ===== core/ipa_pkg.sv
// constants, register map and carrier types of the pending/active/priority block
package ipa_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // sizes
   localparam int NUM_IRQ = 33;            // interrupts 0 to 32
   localparam int IRQ_ID_W = 6;
   localparam int PRIO_W = 4;
   localparam int NUM_PRIO_REGS = 9;
   localparam int NUM_PRIO_FIELDS = 36;    // four fields per priority register
   localparam int LANES = 4;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int PRIO_LSB = 4;            // only bits 7:4 of a lane are stored

   ////////////////////////////////////////////////////////////////////////////
   // register offsets within the block
   localparam logic [11:0] OFS_SET_PENDING = 12'h200;
   localparam logic [11:0] OFS_CLEAR_PENDING = 12'h280;
   localparam logic [11:0] OFS_ACTIVE_FLAGS = 12'h300;
   localparam logic [11:0] OFS_PRIORITY_0 = 12'h400;
   localparam logic [11:0] OFS_PRIORITY_8 = 12'h420;
   localparam logic [11:0] OFS_EVENT_STATUS = 12'h500;
   localparam logic [11:0] OFS_EVENT_MASK = 12'h504;

   ////////////////////////////////////////////////////////////////////////////
   // event status layout and reset values
   localparam int EV_HW_PEND = 0;          // a request line made an interrupt pending
   localparam int EV_SW_PEND = 1;          // a software write made an interrupt pending
   localparam int EV_W = 2;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [3:0] RST_PRIO = 4'h0;
   localparam logic [32:0] RST_IRQ_VEC = 33'h0_0000_0000;
   localparam logic [1:0] RST_EV = 2'h0;

   ////////////////////////////////////////////////////////////////////////////
   // carrier types
   typedef struct packed {
      logic valid;
      logic [5:0] id;
      logic [3:0] prio;
   } ipa_req_type;

   typedef struct packed {
      logic entry;
      logic [5:0] entry_id;
      logic leave;
      logic [5:0] leave_id;
   } ipa_core_type;

endpackage

// ===== test/ipa_monitor.sv
// assertion checker of the pending/active/priority block
`timescale 1ns/1ps
module ipa_monitor
   import ipa_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [32:0] irq_line,
   input wire logic [32:0] irq_enable,
   input wire ipa_core_type core_in,
   input wire ipa_req_type irq_req,
   input wire logic irq_out
);
   logic [32:0] en_d;
   logic map_ok;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////
   // enable seen one cycle back, decode of mapped words
   always_ff @(posedge core_clk) begin
      en_d <= irq_enable;
   end
   assign map_ok = (paddr inside {12'h200, 12'h280, 12'h300, 12'h500, 12'h504})
      || (paddr[11:6] == 6'h10 && paddr[5:0] <= 6'h20 && paddr[1:0] == 2'h0);
   AST_READY: assert property (psel && !penable && ce |=> pready) else $error("no answer to setup");
   AST_READY_ONE: assert property (pready |=> !pready) else $error("ready held too long");
   AST_ERR_READY: assert property (pslverr |-> pready) else $error("error without ready");
   AST_UNMAPPED: assert property (pready && !map_ok |-> pslverr && prdata == 32'h0)
      else $error("unmapped access accepted");
   AST_LOW_NIBBLE: assert property (pready && !pwrite && paddr[11:8] == 4'h4
      |-> (prdata & 32'h0F0F_0F0F) == 32'h0) else $error("priority low nibble set");
   AST_REQ_ENABLED: assert property (irq_req.valid |-> en_d[irq_req.id]) else $error("disabled offered");
   AST_REQ_RANGE: assert property (irq_req.valid |-> irq_req.id < 6'h21) else $error("offer id out of range");
   AST_ENTRY: assert property (core_in.entry && core_in.entry_id < 6'h21
      |=> ##1 !(irq_req.valid && irq_req.id == $past(core_in.entry_id, 2))) else $error("active offered again");
   AST_RESET: assert property ($rose(nrst) |-> !pready && !pslverr && !irq_out && !irq_req.valid)
      else $error("outputs busy after reset");
   cover property (pslverr);
   cover property (core_in.entry);
   cover property (irq_out);
endmodule // ipa_monitor

bind ipa_regs ipa_monitor mon (.core_clk(core_clk), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .irq_line(irq_line), .irq_enable(irq_enable), .core_in(core_in), .irq_req(irq_req),
   .irq_out(irq_out));

// ===== test/ipa_core_model.sv
// processor-side model: takes the offered interrupt, returns on command
`timescale 1ns/1ps
module ipa_core_model
   import ipa_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic take,
   input wire logic ret,
   input wire ipa_req_type req,
   output ipa_core_type core
);
   logic [5:0] id_r;
   ////////////////////////////////////////
   // one-cycle entry and return pulses
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         core <= '0;
         id_r <= 6'h0;
      end else begin
         core.entry <= take && req.valid;
         core.entry_id <= req.id;
         core.leave <= ret;
         core.leave_id <= id_r;
         if (take && req.valid) begin
            id_r <= req.id;
         end
      end
   end
endmodule // ipa_core_model

// ===== test/test_irq_pending_active_priority.sv
// self-checking bench of the pending/active/priority block
`timescale 1ns/1ps
module test_irq_pending_active_priority;
   import ipa_pkg::*;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic ce = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, take = 1'b0, ret = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] pstrb = 4'h0;
   logic [32:0] irq_line = 33'h0, irq_enable = 33'h0;
   logic pready, pslverr, irq_out, er;
   ipa_core_type core_in;
   ipa_req_type irq_req;
   int err_count = 0, checked = 0;
   always #5 core_clk = ~core_clk;
   ipa_regs uut (.core_clk(core_clk), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq_line(irq_line), .irq_enable(irq_enable), .core_in(core_in), .irq_req(irq_req), .irq_out(irq_out));
   ipa_core_model core_m (.core_clk(core_clk), .nrst(nrst), .take(take), .ret(ret), .req(irq_req), .core(core_in));
   ////////////////////////////////////////
   // verdict, comparison and bus tasks
   task automatic tally_and_finish();
      $display("errors %0d checks %0d", err_count, checked);
      if (err_count == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic apb(bit w, logic [11:0] a, logic [31:0] d, logic [3:0] s);
      int n;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         err_count++;
         tally_and_finish();
      end
   endtask
   task automatic wr(logic [11:0] a, logic [31:0] d);
      apb(1'b1, a, d, 4'hF);
   endtask
   task automatic rc(string n, logic [11:0] a, logic [31:0] e);
      apb(1'b0, a, 32'h0, 4'h0);
      chk(n, e, rd);
   endtask
   ////////////////////////////////////////
   // scenarios
   task automatic t_reset();
      rc("set", 12'h200, 32'h0);
      rc("active", 12'h300, 32'h0);
      rc("prio8", 12'h420, 32'h0);
      rc("mask", 12'h504, 32'h0);
      apb(1'b0, 12'h100, 32'h0, 4'h0);
      chk("unmapped", 32'h1, 32'(er));
   endtask
   task automatic t_pend();
      wr(12'h200, 32'h0000_0005);
      wr(12'h200, 32'h0000_0001);
      rc("set", 12'h200, 32'h0000_0005);
      rc("clear view", 12'h280, 32'h0000_0005);
      chk("req idle", 32'h0, 32'(irq_req.valid));
      wr(12'h280, 32'h0000_0004);
      wr(12'h200, 32'h0);
      wr(12'h280, 32'h0);
      rc("after clear", 12'h200, 32'h0000_0001);
      wr(12'h280, 32'h0000_0001);
   endtask
   task automatic t_prio();
      for (int m = 0; m < 9; m++) begin
         wr(12'h400 + 12'(4 * m), 32'hFFFF_FFFF);
         apb(1'b1, 12'h400 + 12'(4 * m), 32'h5A5A_5A5A, 4'(1 << (m % 4)));
         rc("prio", 12'h400 + 12'(4 * m), 32'hF0F0_F0F0 & ~(32'hA0 << (8 * (m % 4))));
         wr(12'h400 + 12'(4 * m), 32'h0);
      end
   endtask
   task automatic t_active();
      wr(12'h400, 32'h8000_0000);
      wr(12'h404, 32'h0000_2000);
      irq_enable <= 33'h28;
      wr(12'h200, 32'h0000_0028);
      repeat (2) @(posedge core_clk);
      chk("best id", 32'h5, 32'(irq_req.id));
      chk("best prio", 32'h2, 32'(irq_req.prio));
      take <= 1'b1;
      @(posedge core_clk);
      take <= 1'b0;
      rc("active", 12'h300, 32'h0000_0020);
      wr(12'h200, 32'h0000_0020);
      wr(12'h280, 32'h0000_0020);
      rc("active kept", 12'h300, 32'h0000_0020);
      ret <= 1'b1;
      @(posedge core_clk);
      ret <= 1'b0;
      rc("pend", 12'h200, 32'h0000_0008);
      rc("idle", 12'h300, 32'h0);
      chk("next id", 32'h3, 32'(irq_req.id));
      wr(12'h280, 32'h0000_0008);
      irq_enable <= 33'h0;
   endtask
   task automatic t_line();
      apb(1'b0, 12'h500, 32'h0, 4'h0);
      wr(12'h504, 32'h0);
      irq_line <= 33'h80;
      repeat (3) @(posedge core_clk);
      chk("masked", 32'h0, 32'(irq_out));
      rc("line pend", 12'h200, 32'h80);
      wr(12'h280, 32'h80);
      rc("level keeps", 12'h200, 32'h80);
      wr(12'h504, 32'h1);
      repeat (2) @(posedge core_clk);
      chk("irq", 32'h1, 32'(irq_out));
      irq_line <= 33'h0;
      wr(12'h280, 32'h80);
      rc("status", 12'h500, 32'h1);
      repeat (2) @(posedge core_clk);
      chk("irq gone", 32'h0, 32'(irq_out));
      rc("line gone", 12'h200, 32'h0);
   endtask
   // a request pulse while the clock enable is low must leave no trace
   task automatic t_freeze();
      ce <= 1'b0;
      irq_line <= 33'h2;
      repeat (3) @(posedge core_clk);
      irq_line <= 33'h0;
      @(posedge core_clk);
      ce <= 1'b1;
      rc("frozen", 12'h200, 32'h0);
      chk("frozen irq", 32'h0, 32'(irq_out));
   endtask
   ////////////////////////////////////////
   // main sequence
   initial begin
      repeat (8) @(posedge core_clk);
      nrst <= 1'b1;
      t_reset();
      t_pend();
      t_prio();
      t_active();
      t_line();
      t_freeze();
      tally_and_finish();
   end
endmodule // test_irq_pending_active_priority
